// ---- psir_regs.v ----
// status, interrupt mask and change-latch registers behind the mdio port
//
// Summary of operation
// - speed bit is 1 in 100 Mb/s mode
// - transmit bit follows frame transmission activity
// - receive bit follows frame reception activity
// - collision bit is 1 during collision
// - link bit shows current link state
// - duplex bit is 1 when full-duplex
// - mode bit 1 automatic, 0 forced
// - negotiation-complete bit mirrors basic status bit
// - polarity bit set on reversed receive polarity
// - read-only pause capability bit
// - error bit sticky until source registers read
// - negotiation-done interrupt only when mask set
// - speed change interrupt only when mask set
// - duplex change interrupt only when mask set
// - link change interrupt only when mask set
// - negotiation-done flag sets, clears on read
// - speed change flag latched until read
// - duplex change flag latched until read
// - link change flag latched until read
`timescale 1ns/1ps
`include "psir_defs.vh"

module psir_regs #(
    parameter [4:0] PHY_ADDR = 5'h00       // station address, plain default
) (
    input  wire clk,                       // 10 MHz system clock
    input  wire sys_rst,                   // synchronous, active high
    input  wire mdc_pin,                   // management clock from host
    input  wire mdio_in,                   // management data pin level
    output wire mdio_out,                  // data driven onto the pin
    output wire mdio_oe_n,                 // low while this block drives
    input  wire speed_100,                 // 100 Mb/s twisted-pair mode
    input  wire tx_active,                 // frame being sent
    input  wire rx_active,                 // frame being received
    input  wire collision,                 // collision in progress
    input  wire link_up,                   // link state
    input  wire full_duplex,               // duplex mode
    input  wire autoneg_enabled,           // automatic negotiation mode
    input  wire autoneg_complete,          // basic status completion bit
    input  wire polarity_reversed,         // reversed receive polarity
    input  wire pause_capable,             // flow-control pause ability
    input  wire fault_event,               // remote, jabber or pd fault
    input  wire fault_source_read,         // fault source registers read
    output wire mgmt_irq                   // interrupt request, active high
);

    // frame engine states
    localparam [2:0] ST_PRE   = 3'h0;      // counting preamble ones
    localparam [2:0] ST_HDR   = 3'h1;      // start, opcode, addresses
    localparam [2:0] ST_TA_RD = 3'h2;      // read turnaround
    localparam [2:0] ST_RD    = 3'h3;      // shifting read data out
    localparam [2:0] ST_TA_WR = 3'h4;      // write turnaround
    localparam [2:0] ST_WR    = 3'h5;      // shifting write data in

    // pin synchronisers
    reg         mdc_s1_q;                  // first stage, feeds s2 only
    reg         mdc_s2_q;                  // synchronised clock level
    reg         mdc_s3_q;                  // delayed copy for edge find
    reg         mdio_s1_q;                 // first stage, feeds s2 only
    reg         mdio_s2_q;                 // synchronised data
    reg         mdio_s3_q;                 // data as it was before the edge
    wire        mdc_rise;                  // one-cycle rising edge pulse
    wire        bit_in;                    // sampled frame bit

    // frame engine
    reg  [2:0]  state_q;                   // engine state
    reg  [5:0]  cnt_q;                     // bit counter
    reg  [12:0] hdr_q;                     // header bits collected so far
    reg  [4:0]  reg_addr_q;                // addressed register
    reg  [15:0] shift_q;                   // read or write data shifter
    reg         mdio_out_q;                // pin data
    reg         mdio_oe_n_q;               // pin enable, low drives
    wire [13:0] hdr_full;                  // header with the newest bit
    wire [15:0] wr_full;                   // write data with newest bit

    // register contents and side effects
    reg  [3:0]  mask_q;                    // done, speed, duplex, link
    reg         err_q;                     // sticky fault indicator
    reg         change_rd_q;               // pulse: change register read
    reg         irq_q;                     // interrupt request
    wire [3:0]  flags;                     // done, speed, duplex, link
    wire [15:0] status2;                   // live second status word
    wire [15:0] rd_word;                   // word for the addressed reg

    // select the word returned for a register address; unmapped
    // addresses inside this group answer zero so a read always ends
    function [15:0] psir_rd_mux;
        input [4:0]  addr;
        input [15:0] s2;
        input [3:0]  m;
        input [3:0]  f;
        begin
            case (addr)
                `PSIR_REG_STATUS2: psir_rd_mux = s2;
                `PSIR_REG_MASK:    psir_rd_mux = {8'h00, m, 4'h0};
                `PSIR_REG_CHANGE:  psir_rd_mux = {8'h00, f, 4'h0};
                default:           psir_rd_mux = 16'h0000;
            endcase
        end
    endfunction

    // two flops on each pin before any logic looks at it; the edge
    // finder reads the second and third stages, never the first
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            mdc_s1_q  <= 1'h0;
            mdc_s2_q  <= 1'h0;
            mdc_s3_q  <= 1'h0;
            mdio_s1_q <= 1'h1;
            mdio_s2_q <= 1'h1;
            mdio_s3_q <= 1'h1;
        end
        else
        begin
            mdc_s1_q  <= mdc_pin;
            mdc_s2_q  <= mdc_s1_q;
            mdc_s3_q  <= mdc_s2_q;
            mdio_s1_q <= mdio_in;
            mdio_s2_q <= mdio_s1_q;
            mdio_s3_q <= mdio_s2_q;
        end
    end

    // data is taken one sample older than the clock edge, so it is
    // the level that stood before the host moved it after the edge;
    // the cost is one system clock of setup needed on the pin
    assign mdc_rise = mdc_s2_q & ~mdc_s3_q;
    assign bit_in   = mdio_s3_q;
    assign hdr_full = {hdr_q, bit_in};
    assign wr_full  = {shift_q[14:0], bit_in};

    // live status word; reserved bits read as zero
    assign status2 = {
        1'h0,
        speed_100,
        tx_active,
        rx_active,
        collision,
        link_up,
        full_duplex,
        autoneg_enabled,
        autoneg_complete,
        1'h0,
        polarity_reversed,
        pause_capable,
        err_q,
        3'h0
    };

    assign rd_word = psir_rd_mux(reg_addr_q, status2, mask_q, flags);

    // frame engine: all moves happen on a management clock rising edge
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q     <= ST_PRE;
            cnt_q       <= 6'h00;
            hdr_q       <= 13'h0000;
            reg_addr_q  <= 5'h00;
            shift_q     <= 16'h0000;
            mdio_out_q  <= 1'h1;
            mdio_oe_n_q <= 1'h1;
            mask_q      <= `PSIR_MASK_RST;
            change_rd_q <= 1'h0;
        end
        else
        begin
            change_rd_q <= 1'h0;           // pulse by default
            if (mdc_rise)
            begin
                case (state_q)
                    ST_PRE:
                    begin
                        // need a full run of ones, then the first start bit
                        if (bit_in)
                        begin
                            if (cnt_q != `PSIR_PRE_LEN)
                                cnt_q <= cnt_q + 6'h01;
                        end
                        else if (cnt_q == `PSIR_PRE_LEN)
                        begin
                            state_q <= ST_HDR;
                            hdr_q   <= 13'h0000;
                            cnt_q   <= 6'h01;
                        end
                        else
                            cnt_q <= 6'h00;
                    end
                    ST_HDR:
                    begin
                        hdr_q <= hdr_full[12:0];
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == `PSIR_HDR_BITS - 1)
                        begin
                            cnt_q      <= 6'h00;
                            reg_addr_q <= hdr_full[4:0];
                            // frames for another station are let pass
                            if (hdr_full[13:12] != `PSIR_ST_CODE ||
                                hdr_full[9:5] != PHY_ADDR)
                                state_q <= ST_PRE;
                            else if (hdr_full[11:10] == `PSIR_OP_READ)
                                state_q <= ST_TA_RD;
                            else if (hdr_full[11:10] == `PSIR_OP_WRITE)
                                state_q <= ST_TA_WR;
                            else
                                state_q <= ST_PRE;
                        end
                    end
                    ST_TA_RD:
                    begin
                        // second turnaround bit: drive zero, snapshot data
                        mdio_oe_n_q <= 1'h0;
                        mdio_out_q  <= 1'h0;
                        shift_q     <= rd_word;
                        cnt_q       <= 6'h00;
                        state_q     <= ST_RD;
                        // the snapshot is the read that clears the latches
                        if (reg_addr_q == `PSIR_REG_CHANGE)
                            change_rd_q <= 1'h1;
                    end
                    ST_RD:
                    begin
                        if (cnt_q == `PSIR_DATA_BITS)
                        begin
                            // last bit has been sampled; let go of the pin
                            mdio_oe_n_q <= 1'h1;
                            mdio_out_q  <= 1'h1;
                            cnt_q       <= 6'h00;
                            state_q     <= ST_PRE;
                        end
                        else
                        begin
                            mdio_out_q <= shift_q[15];
                            shift_q    <= {shift_q[14:0], 1'h0};
                            cnt_q      <= cnt_q + 6'h01;
                        end
                    end
                    ST_TA_WR:
                    begin
                        // host drives both turnaround bits; skip them
                        cnt_q <= cnt_q + 6'h01;
                        if (cnt_q == 6'h01)
                        begin
                            cnt_q   <= 6'h00;
                            state_q <= ST_WR;
                        end
                    end
                    ST_WR:
                    begin
                        shift_q <= wr_full;
                        cnt_q   <= cnt_q + 6'h01;
                        if (cnt_q == `PSIR_DATA_BITS - 1)
                        begin
                            cnt_q   <= 6'h00;
                            state_q <= ST_PRE;
                            // only the four mask bits are stored; the
                            // unused positions are dropped and read zero
                            if (reg_addr_q == `PSIR_REG_MASK)
                                mask_q <= wr_full[`PSIR_EVT_HI:
                                                  `PSIR_EVT_LO];
                        end
                    end
                    default:
                    begin
                        mdio_oe_n_q <= 1'h1;
                        mdio_out_q  <= 1'h1;
                        cnt_q       <= 6'h00;
                        state_q     <= ST_PRE;
                    end
                endcase
            end
        end
    end

    // sticky fault bit: a new fault in the clearing cycle still sets it
    always @(posedge clk)
    begin
        if (sys_rst)
            err_q <= 1'h0;
        else
            err_q <= fault_event | (err_q & ~fault_source_read);
    end

    // negotiation done: rising completion latched until read
    psir_evlatch #(
        .RISE_ONLY (1)
    ) u_done (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   (autoneg_complete),
        .clr     (change_rd_q),
        .flag    (flags[3])
    );

    // speed change latched until read
    psir_evlatch #(
        .RISE_ONLY (0)
    ) u_speed (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   (speed_100),
        .clr     (change_rd_q),
        .flag    (flags[2])
    );

    // duplex change latched until read
    psir_evlatch #(
        .RISE_ONLY (0)
    ) u_duplex (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   (full_duplex),
        .clr     (change_rd_q),
        .flag    (flags[1])
    );

    // link change latched until read
    psir_evlatch #(
        .RISE_ONLY (0)
    ) u_link (
        .clk     (clk),
        .sys_rst (sys_rst),
        .level   (link_up),
        .clr     (change_rd_q),
        .flag    (flags[0])
    );

    // interrupt: any latched flag whose mask bit is set; one cycle
    // behind the flags, so it drops two cycles after a clearing read
    always @(posedge clk)
    begin
        if (sys_rst)
            irq_q <= 1'h0;
        else
            irq_q <= (flags[3] & mask_q[3]) |
                     (flags[2] & mask_q[2]) |
                     (flags[1] & mask_q[1]) |
                     (flags[0] & mask_q[0]);
    end

    assign mgmt_irq  = irq_q;
    assign mdio_out  = mdio_out_q;
    assign mdio_oe_n = mdio_oe_n_q;

endmodule // psir_regs

// ---- psir_defs.vh ----
// constants for the transceiver status, mask and change-latch registers
`ifndef PSIR_DEFS_VH
`define PSIR_DEFS_VH

// management register addresses (5-bit register field of a frame)
`define PSIR_REG_STATUS2      5'h11
`define PSIR_REG_MASK         5'h12
`define PSIR_REG_CHANGE       5'h13

// second status register bit positions
`define PSIR_S2_SPEED         14
`define PSIR_S2_TX            13
`define PSIR_S2_RX            12
`define PSIR_S2_COL           11
`define PSIR_S2_LINK          10
`define PSIR_S2_DUPLEX        9
`define PSIR_S2_ANMODE        8
`define PSIR_S2_NEGOTIATION_DONE_FLAG        7
`define PSIR_S2_POL           5
`define PSIR_S2_PAUSE         4
`define PSIR_S2_ERR           3

// mask and change-latch fields: bits 7..4 = done, speed, duplex, link
`define PSIR_EVT_HI           7
`define PSIR_EVT_LO           4

// reset values
`define PSIR_MASK_RST         4'h0
`define PSIR_FLAG_RST         1'h0

// frame layout and timing counts, in management clock bits
`define PSIR_PRE_LEN          32
`define PSIR_HDR_BITS         14
`define PSIR_DATA_BITS        16
`define PSIR_ST_CODE          2'h1
`define PSIR_OP_READ          2'h2
`define PSIR_OP_WRITE         2'h1

`endif

// ---- psir_evlatch.v ----
// sticky change-event latch with clear-on-read, set winning over clear
`timescale 1ns/1ps

module psir_evlatch #(
    parameter RISE_ONLY = 0                // 1: only rising edges count
) (
    input  wire clk,
    input  wire sys_rst,
    input  wire level,                     // watched state, same domain
    input  wire clr,                       // read of the change register
    output wire flag                       // latched event
);

    reg  prev_q;                           // last cycle's copy of level
    reg  primed_q;                         // prev_q holds a real sample
    reg  flag_q;                           // sticky event flag
    wire evt;                              // change seen this cycle

    // a change is the current level against the registered copy;
    // the first cycle after reset only primes the copy, so a link
    // that is already up at reset does not fake an event
    assign evt = primed_q &
                 (RISE_ONLY ? (level & ~prev_q) : (level ^ prev_q));

    // copy of previous state
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            prev_q   <= 1'h0;
            primed_q <= 1'h0;
        end
        else
        begin
            prev_q   <= level;
            primed_q <= 1'h1;
        end
    end

    // flag: an event in the clearing cycle survives the clear
    always @(posedge clk)
    begin
        if (sys_rst)
            flag_q <= `PSIR_FLAG_RST;
        else
            flag_q <= evt | (flag_q & ~clr);
    end

    assign flag = flag_q;

endmodule // psir_evlatch

// ---- psir_regs_asserts.sv ----
// assertion checker for the status, mask and change-latch register block
`timescale 1ns/1ps

module psir_regs_asserts (
    input logic clk,                // system clock
    input logic sys_rst,            // synchronous reset, active high
    input logic mdc_pin,            // management clock pin
    input logic mdio_out,           // data driven by the block
    input logic mdio_oe_n,          // drive enable, active low
    input logic speed_100,          // watched speed level
    input logic link_up,            // watched link level
    input logic full_duplex,        // watched duplex level
    input logic autoneg_complete,   // watched completion level
    input logic mgmt_irq            // interrupt request
);
    logic [5:0] mdc_age_q;          // clocks since last mdc rise, saturating
    logic [2:0] evt_age_q;          // clocks since last watched change

    // ages let the checks bound causes without seeing the mask register
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            mdc_age_q <= 6'h3F;
            evt_age_q <= 3'h7;
        end
        else
        begin
            if ($rose(mdc_pin))
                mdc_age_q <= 6'h00;
            else if (mdc_age_q != 6'h3F)
                mdc_age_q <= mdc_age_q + 6'h01;
            if ($changed(speed_100) || $changed(link_up) ||
                $changed(full_duplex) || $rose(autoneg_complete))
                evt_age_q <= 3'h0;
            else if (evt_age_q != 3'h7)
                evt_age_q <= evt_age_q + 3'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // host is mid-frame: an mdc rise was seen within the last bit period
    sequence s_host_busy;
        mdc_age_q < 6'h0A;
    endsequence
    // a watched level moved a few clocks ago
    sequence s_recent_evt;
        evt_age_q < 3'h5;
    endsequence

    a_reset_quiet: assert property ($fell(sys_rst) |->
        mdio_oe_n && mdio_out && !mgmt_irq)
        else $error("outputs not idle after reset");
    a_irq_cause: assert property (
        $rose(mgmt_irq) |-> s_recent_evt or s_host_busy)
        else $error("interrupt rose without an event");
    a_irq_clear: assert property (
        $fell(mgmt_irq) |-> s_host_busy)
        else $error("interrupt fell outside a frame");
    a_irq_hold: assert property (
        mgmt_irq && mdc_age_q > 6'h0C |=> mgmt_irq)
        else $error("interrupt dropped while no frame ran");
    a_drive_window: assert property (!mdio_oe_n |-> mdc_age_q < 6'h0C)
        else $error("pin driven outside a frame");
    a_idle_high: assert property (mdio_oe_n |-> mdio_out)
        else $error("data not high while released");
    a_ta_zero: assert property ($fell(mdio_oe_n) |->
        (!mdio_out && !mdio_oe_n) [*8])
        else $error("turnaround bit not held low");
    a_out_timing: assert property ($changed(mdio_out) |->
        mdc_age_q inside {[6'h01:6'h06]})
        else $error("data changed away from an mdc rise");
endmodule // psir_regs_asserts

bind psir_regs psir_regs_asserts u_psir_chk (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .mdc_pin          (mdc_pin),
    .mdio_out         (mdio_out),
    .mdio_oe_n        (mdio_oe_n),
    .speed_100        (speed_100),
    .link_up          (link_up),
    .full_duplex      (full_duplex),
    .autoneg_complete (autoneg_complete),
    .mgmt_irq         (mgmt_irq)
);

// ---- psir_host_model.sv ----
// management station model that runs frames on the mdc and mdio wires
`timescale 1ns/1ps

module psir_host_model (
    input  logic clk,          // bit timing is counted in system clocks
    input  logic mdio_out,     // data from the device
    input  logic mdio_oe_n,    // device drive enable, active low
    output logic mdc_pin,      // management clock, stands low between frames
    output logic mdio_in       // resolved wire level
);
    logic drv_en;              // host drives the wire
    logic drv_bit;             // level the host drives

    // released wire floats to the pull-up level, never the last value
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_bit : 1'b1);

    initial
    begin
        mdc_pin = 1'b0;
        drv_en  = 1'b0;
        drv_bit = 1'b1;
    end

    // one bit: five clocks low, five high; data moves only at the fall
    task automatic bit_cycle(input logic en, input logic b, output logic s);
        mdc_pin = 1'b0;
        drv_en  = en;
        drv_bit = b;
        repeat (5) @(negedge clk);
        s       = mdio_in;
        mdc_pin = 1'b1;
        repeat (5) @(negedge clk);
    endtask

    // full frame with its own preamble; reads release from turnaround on
    task automatic frame(input logic [1:0] op, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd,
                         output logic [15:0] rd, output logic ta);
        logic [63:0] bits;
        logic        s;
        bits = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
        for (int i = 63; i >= 0; i--)
        begin
            bit_cycle(!(op == 2'h2 && i < 18), bits[i], s);
            if (i == 16)
                ta = s;
            if (i < 16)
                rd[i] = s;
        end
        mdc_pin = 1'b0;
        drv_en  = 1'b0;
        // one idle clock so a following frame never re-drives in this step
        @(negedge clk);
    endtask
endmodule // psir_host_model

// ---- test_psir_regs.sv ----
// self-checking bench for the status, mask and change-latch registers
`timescale 1ns/1ps
`include "psir_defs.vh"

module test_psir_regs;
    logic        clk;               // 10 MHz system clock
    logic        sys_rst;           // synchronous reset, active high
    logic        mdc_pin;           // management clock from the host
    logic        mdio_in;           // resolved management wire
    logic        mdio_out;          // device data
    logic        mdio_oe_n;         // device drive enable, active low
    logic        mgmt_irq;          // interrupt request
    logic [15:0] st_q;              // status levels in status layout
    logic        fault_event;       // error source pulse
    logic        fault_source_read; // error clear pulse
    logic [15:0] ef;                // expected change flags
    logic [15:0] rd;                // last read data
    logic        ta;                // last sampled turnaround bit
    int          err_count;         // mismatches
    int          comparisons;       // comparisons made
    int          sb [10] = '{14, 13, 12, 11, 10, 9, 8, 7, 5, 4};
    int          evb [4] = '{7, 14, 9, 10}; // done, speed, duplex, link

    initial clk = 1'b0;
    always #50 clk = ~clk;

    psir_regs #(.PHY_ADDR(5'h05)) dut (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .mdc_pin           (mdc_pin),
        .mdio_in           (mdio_in),
        .mdio_out          (mdio_out),
        .mdio_oe_n         (mdio_oe_n),
        .speed_100         (st_q[14]),
        .tx_active         (st_q[13]),
        .rx_active         (st_q[12]),
        .collision         (st_q[11]),
        .link_up           (st_q[10]),
        .full_duplex       (st_q[9]),
        .autoneg_enabled   (st_q[8]),
        .autoneg_complete  (st_q[7]),
        .polarity_reversed (st_q[5]),
        .pause_capable     (st_q[4]),
        .fault_event       (fault_event),
        .fault_source_read (fault_source_read),
        .mgmt_irq          (mgmt_irq)
    );

    psir_host_model host (
        .clk       (clk),
        .mdio_out  (mdio_out),
        .mdio_oe_n (mdio_oe_n),
        .mdc_pin   (mdc_pin),
        .mdio_in   (mdio_in)
    );

    task automatic chk16(input string nm, input logic [15:0] exp,
                         input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk1(input string nm, input logic exp, input logic got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %s expected %b seen %b", nm, exp, got);
        end
    endtask

    // read frame; the device must pull the second turnaround bit low
    task automatic rd_reg(input logic [4:0] ra, input logic [15:0] exp);
        host.frame(2'h2, 5'h05, ra, 16'h0000, rd, ta);
        chk1("turnaround", 1'b0, ta);
        chk16($sformatf("register %h", ra), exp, rd);
    endtask

    task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
        host.frame(2'h1, 5'h05, ra, wd, rd, ta);
    endtask

    // flip one event level; completion only counts on its rise
    task automatic toggle(input int k);
        @(negedge clk);
        st_q[evb[k]] = ~st_q[evb[k]];
        if (k != 0 || st_q[7])
            ef[7 - k] = 1'b1;
    endtask

    task automatic finish_test;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog, well beyond the roughly 2.5 ms the sequence needs
    initial
    begin
        #8_000_000;
        err_count++;
        $display("Error watchdog expected done seen timeout");
        finish_test;
    end

    initial
    begin
        sys_rst           = 1'b1;
        st_q              = 16'h0000;
        fault_event       = 1'b0;
        fault_source_read = 1'b0;
        ef                = 16'h0000;
        err_count         = 0;
        comparisons       = 0;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        chk1("irq after reset", 1'b0, mgmt_irq);
        rd_reg(`PSIR_REG_MASK, 16'h0000);
        rd_reg(`PSIR_REG_CHANGE, 16'h0000);
        // walking one across every status input, masks all off
        foreach (sb[n])
        begin
            @(negedge clk);
            st_q = 16'h0001 << sb[n];
            rd_reg(`PSIR_REG_STATUS2, st_q);
        end
        chk1("irq all masked", 1'b0, mgmt_irq);
        rd_reg(`PSIR_REG_CHANGE, 16'h00F0);
        rd_reg(`PSIR_REG_CHANGE, 16'h0000);
        // error bit is sticky until its sources are read
        @(negedge clk);
        st_q        = 16'h0000;
        fault_event = 1'b1;
        @(negedge clk);
        fault_event = 1'b0;
        rd_reg(`PSIR_REG_STATUS2, 16'h0008);
        rd_reg(`PSIR_REG_STATUS2, 16'h0008);
        @(negedge clk);
        fault_source_read = 1'b1;
        @(negedge clk);
        fault_source_read = 1'b0;
        rd_reg(`PSIR_REG_STATUS2, 16'h0000);
        // read-only write, unmapped read, foreign station address
        wr_reg(`PSIR_REG_STATUS2, 16'hFFFF);
        rd_reg(`PSIR_REG_STATUS2, 16'h0000);
        rd_reg(5'h14, 16'h0000);
        toggle(3);
        host.frame(2'h2, 5'h06, `PSIR_REG_CHANGE, 16'h0000, rd, ta);
        chk16("foreign read", 16'hFFFF, rd);
        rd_reg(`PSIR_REG_CHANGE, ef);
        ef = 16'h0000;
        // each mask alone: other source stays quiet, own source fires
        for (int k = 0; k < 4; k++)
        begin
            wr_reg(`PSIR_REG_MASK, 16'h0010 << (3 - k));
            rd_reg(`PSIR_REG_MASK, 16'h0010 << (3 - k));
            toggle((k + 1) % 4);
            repeat (4) @(negedge clk);
            chk1("irq other source", 1'b0, mgmt_irq);
            toggle(k);
            // long wait: the request must stand while no frame runs
            repeat (20) @(negedge clk);
            chk1("irq own source", 1'b1, mgmt_irq);
            rd_reg(`PSIR_REG_CHANGE, ef);
            ef = 16'h0000;
            repeat (2) @(negedge clk);
            chk1("irq after read", 1'b0, mgmt_irq);
        end
        // mid-run reset drops mask, flags and request
        wr_reg(`PSIR_REG_MASK, 16'h00F0);
        toggle(3);
        repeat (4) @(negedge clk);
        chk1("irq before reset", 1'b1, mgmt_irq);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        chk1("irq after second reset", 1'b0, mgmt_irq);
        rd_reg(`PSIR_REG_MASK, 16'h0000);
        rd_reg(`PSIR_REG_CHANGE, 16'h0000);
        finish_test;
    end
endmodule // test_psir_regs
